// >>> hdl/pmc_defs.vh
// Register offsets, field positions, reset values and timing figures of the
// parallel master port configuration block.
// Assumes inclusion by bare name from the block's design file.
`ifndef PMC_DEFS_VH
`define PMC_DEFS_VH

// Register byte offsets on the APB bus
`define PMC_OFF_MODE 8'h00
`define PMC_OFF_STATUS 8'h04
`define PMC_OFF_STROBE 8'h08
`define PMC_OFF_ADDR_EN 8'h0c
`define PMC_OFF_CS1_CFG 8'h10
`define PMC_OFF_CS2_CFG 8'h14
`define PMC_OFF_CS1_BASE 8'h18
`define PMC_OFF_CS2_BASE 8'h1c
`define PMC_OFF_CS1_MODE 8'h20
`define PMC_OFF_CS2_MODE 8'h24
`define PMC_OFF_REQUEST 8'h28

// Reset values
`define PMC_CS1_BASE_RST 16'h0200
`define PMC_CS2_BASE_RST 16'h0600
`define PMC_REG_RST 16'h0000

// Status register fields
`define PMC_ST_BUSY 15
`define PMC_ST_ERROR 13
`define PMC_ST_TIMEOUT 12

// Strobe enable and latch timing fields
`define PMC_SE_WR_EN 15
`define PMC_SE_RD_EN 14
`define PMC_SE_BE1_EN 13
`define PMC_SE_BE0_EN 12
`define PMC_SE_ALW_HI 10
`define PMC_SE_ALW_LO 9
`define PMC_SE_HOLD 8

// Chip select configuration fields
`define PMC_CF_OFF 15
`define PMC_CF_CSP 14
`define PMC_CF_CSPEN 13
`define PMC_CF_BEP 12
`define PMC_CF_WRITE_STROBE_POLARITY 10
`define PMC_CF_READ_STROBE_POLARITY 9
`define PMC_CF_SM 8
`define PMC_CF_ACK_POLARITY_SEL 7
`define PMC_CF_W_HI 6
`define PMC_CF_W_LO 5
`define PMC_CF_MASK 16'hf7e0

// Chip select mode fields
`define PMC_MD_ACK_HI 15
`define PMC_MD_ACK_LO 14
`define PMC_MD_DW_HI 5
`define PMC_MD_DW_LO 2
`define PMC_MD_MASK 16'hc03c

// Request register fields
`define PMC_RQ_WRITE 24

// Masks of implemented bits
`define PMC_BASE_MASK 16'hff88
`define PMC_STROBE_MASK 16'hf77f

// Codes
`define PMC_MODE_MASTER 2'h3
`define PMC_WIDTH_RSVD 2'h3
`define PMC_WIDTH_16 2'h2
`define PMC_ACK_NONE 2'h0
`define PMC_ACK_TIMEOUT 2'h1

// Timing in instruction cycles, and quarter cycles per instruction cycle
`define PMC_ACK_MAX_TCY 16'd255
`define PMC_QTR_PER_TCY 16'd4

`endif

// >>> hdl/pmc_port.v
// Configuration, status and chip-select timing of a parallel master port.
// Assumes an APB master on clk and external parts on the strobe pins.
//
// Summary of operation
// - Busy flag reads one while a master transaction runs, only in master mode.
// - Illegal transaction request sets a sticky error flag cleared by software.
// - Acknowledge time-out sets a sticky time-out flag cleared only by software.
// - Eight bits give top of reserved space; zero means top is 0xffffff.
// - Four bits enable write, read, high and low byte-enable pins.
// - Two bits set latch strobe width of 1/2 to 3 1/2 cycles.
// - One bit sets address hold after latch strobe: 1/4 or 1 1/4 cycles.
// - Seven bits make address pins 22 to 16 port lines or general I/O.
// - Address pins 15 and 14 enabled as address or chip select, else I/O.
// - Address pins 13 to 3 enabled as port address lines, else I/O.
// - Address pins 2 to 0 enabled as address or latch strobe, else I/O.
// - Per chip select, a disable bit switches its function off.
// - Per chip select, a polarity bit sets chip select active level.
// - Per chip select, a bit enables its chip select pin.
// - Per chip select, a polarity bit sets both byte-enable active levels.
// - Write polarity bit sets write strobe level, or enable strobe level.
// - Read polarity bit sets read strobe level, or direction signal level.
// - Strobe style bit selects direction plus enable, or separate strobes.
// - Acknowledge polarity bit sets active level of the acknowledge input.
// - Width field: 10 is 16 bits, 01 is 4 bits, 00 is 8; 11 reserved.
// - Base holds address bits 23 to 15 and 11; resets 0x0200 and 0x0600.
// - Second base written zero extends first chip select to top of space.
// - Port mode field value 11 selects master mode.
// - Acknowledge ends a transfer, optionally timing out after wait or 255 cycles.
//
// The implementer's own choices: the APB slave port and the address map.
`include "pmc_defs.vh"
`timescale 1ns/100ps
`default_nettype none

module pmc_port #(
	parameter QTR_CLKS = 2
) (
	// Clock and reset
	input wire clk,
	input wire reset,
	// APB slave
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	// Acknowledge pins
	input wire ack_input_one,
	input wire ack_input_two,
	// Address pins and latch strobe
	output reg [22:0] address_bus_out,
	output reg [22:0] address_bus_oe,
	output reg latch_strobe_low,
	// Chip selects
	output reg chip_select_one_out,
	output reg chip_select_one_oe,
	output reg chip_select_two_out,
	output reg chip_select_two_oe,
	// Strobes and byte enables
	output reg write_strobe_out,
	output reg write_strobe_oe,
	output reg read_strobe_out,
	output reg read_strobe_oe,
	output reg low_byte_enable_out,
	output reg low_byte_enable_oe,
	output reg high_byte_enable_out,
	output reg high_byte_enable_oe
);

	// ---------------------------------------------------------------
	// Constants
	// ---------------------------------------------------------------
	localparam [2:0] ST_IDLE = 3'h0;
	localparam [2:0] ST_LATCH = 3'h1;
	localparam [2:0] ST_HOLD = 3'h2;
	localparam [2:0] ST_STROBE = 3'h3;
	localparam [2:0] ST_ACKW = 3'h4;
	localparam [2:0] ST_END = 3'h5;
	localparam [15:0] QTR = QTR_CLKS[15:0];

	// ---------------------------------------------------------------
	// Registers
	// ---------------------------------------------------------------
	reg [1:0] port_mode_q;
	reg err_q;
	reg tmo_q;
	reg [7:0] reserved_space_top;
	reg [15:0] strobe_q;
	reg [15:0] low_pins_q;
	reg [15:0] cfg_q [0:1];
	reg [15:0] base_q [0:1];
	reg [15:0] mode_q [0:1];
	reg [2:0] st_q;
	reg [2:0] st_d;
	reg [15:0] cnt_q;
	reg [15:0] cnt_d;
	reg sel2_q;
	reg wr_q;
	reg [23:0] addr_q;
	reg tmo_pend_q;
	reg busy_q;
	reg [1:0] ack_s1_q;
	reg [1:0] ack_s2_q;
	reg [1:0] ack_s3_q;
	reg [1:0] ack_f_q;

	wire acc_wr = psel & penable & pwrite;
	wire wr_status = acc_wr & (paddr == `PMC_OFF_STATUS);
	wire wr_req = acc_wr & (paddr == `PMC_OFF_REQUEST);
	wire master = (port_mode_q == `PMC_MODE_MASTER);

	// ---------------------------------------------------------------
	// Acknowledge synchronisers
	// ---------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi = gi + 1) begin : g_ack
			always @(posedge clk) begin
				if (reset) begin
					ack_s1_q[gi] <= 1'b0;
					ack_s2_q[gi] <= 1'b0;
					ack_s3_q[gi] <= 1'b0;
					ack_f_q[gi] <= 1'b0;
				end else begin
					ack_s1_q[gi] <= (gi == 0) ? ack_input_one : ack_input_two;
					ack_s2_q[gi] <= ack_s1_q[gi];
					ack_s3_q[gi] <= ack_s2_q[gi];
					if (ack_s2_q[gi] == ack_s3_q[gi])
						ack_f_q[gi] <= ack_s3_q[gi];
				end
			end
		end
	endgenerate

	// ---------------------------------------------------------------
	// Address decode of a new request
	// ---------------------------------------------------------------
	wire [23:0] rq_addr = pwdata[23:0];
	wire [23:0] base1 = {base_q[0][15:7], 3'h0, base_q[0][3], 11'h000};
	wire [23:0] base2 = {base_q[1][15:7], 3'h0, base_q[1][3], 11'h000};
	wire cs2_none = (base_q[1] == 16'h0000);
	wire below_top = (reserved_space_top == 8'h00) ||
		(rq_addr < {reserved_space_top, 16'h0000});
	wire hit2 = !cs2_none && (rq_addr >= base2) && below_top;
	wire hit1 = (rq_addr >= base1) && (cs2_none || rq_addr < base2);
	wire ok1 = hit1 & !cfg_q[0][`PMC_CF_OFF] &
		(cfg_q[0][`PMC_CF_W_HI:`PMC_CF_W_LO] != `PMC_WIDTH_RSVD);
	wire ok2 = hit2 & !cfg_q[1][`PMC_CF_OFF] &
		(cfg_q[1][`PMC_CF_W_HI:`PMC_CF_W_LO] != `PMC_WIDTH_RSVD);
	wire legal = master & !busy_q & (ok1 | ok2);
	wire start = wr_req & legal;

	// ---------------------------------------------------------------
	// Timing counts
	// ---------------------------------------------------------------
	wire [15:0] cfg = sel2_q ? cfg_q[1] : cfg_q[0];
	wire [15:0] mode = sel2_q ? mode_q[1] : mode_q[0];
	wire [1:0] ack_usage_select = mode[`PMC_MD_ACK_HI:`PMC_MD_ACK_LO];
	wire [15:0] dwait = {12'h000, mode[`PMC_MD_DW_HI:`PMC_MD_DW_LO]};
	wire [15:0] lw = {14'h0000, strobe_q[`PMC_SE_ALW_HI:`PMC_SE_ALW_LO]};
	wire [15:0] latch_cnt = (lw * 16'd4 + 16'd2) * QTR - 16'd1;
	wire [15:0] hold_cnt = (strobe_q[`PMC_SE_HOLD] ? 16'd5 : 16'd1) * QTR - 16'd1;
	wire [15:0] strobe_cnt = (dwait * 16'd4 + (wr_q ? 16'd2 : 16'd3)) * QTR - 16'd1;
	wire [15:0] tmo_tcy = (dwait == 16'h0000) ? `PMC_ACK_MAX_TCY : dwait;
	wire [15:0] tmo_cnt = tmo_tcy * `PMC_QTR_PER_TCY * QTR - 16'd1;
	wire ack_now = ((sel2_q ? ack_f_q[1] : ack_f_q[0]) == cfg[`PMC_CF_ACK_POLARITY_SEL]);

	// ---------------------------------------------------------------
	// Transaction sequencer
	// ---------------------------------------------------------------
	always @* begin
		st_d = st_q;
		cnt_d = cnt_q;
		case (st_q)
			ST_IDLE: begin
				if (start) begin
					st_d = ST_LATCH;
					cnt_d = latch_cnt;
				end
			end
			ST_LATCH: begin
				if (cnt_q == 16'h0000) begin
					st_d = ST_HOLD;
					cnt_d = hold_cnt;
				end else
					cnt_d = cnt_q - 16'd1;
			end
			ST_HOLD: begin
				if (cnt_q == 16'h0000) begin
					st_d = ST_STROBE;
					cnt_d = strobe_cnt;
				end else
					cnt_d = cnt_q - 16'd1;
			end
			ST_STROBE: begin
				if (cnt_q != 16'h0000)
					cnt_d = cnt_q - 16'd1;
				else if (ack_usage_select == `PMC_ACK_NONE)
					st_d = ST_END;
				else begin
					st_d = ST_ACKW;
					cnt_d = tmo_cnt;
				end
			end
			ST_ACKW: begin
				if (ack_now)
					st_d = ST_END;
				else if (ack_usage_select == `PMC_ACK_TIMEOUT && cnt_q == 16'h0000)
					st_d = ST_END;
				else if (ack_usage_select == `PMC_ACK_TIMEOUT)
					cnt_d = cnt_q - 16'd1;
			end
			ST_END: begin
				st_d = ST_IDLE;
			end
			default: begin
				st_d = ST_IDLE;
			end
		endcase
	end

	wire tmo_hit = (st_q == ST_ACKW) && !ack_now &&
		(ack_usage_select == `PMC_ACK_TIMEOUT) && (cnt_q == 16'h0000);

	always @(posedge clk) begin
		if (reset) begin
			st_q <= ST_IDLE;
			cnt_q <= 16'h0000;
			sel2_q <= 1'b0;
			wr_q <= 1'b0;
			addr_q <= 24'h000000;
			tmo_pend_q <= 1'b0;
			busy_q <= 1'b0;
		end else begin
			st_q <= st_d;
			cnt_q <= cnt_d;
			busy_q <= (st_d != ST_IDLE);
			if (start) begin
				sel2_q <= ~ok1;
				wr_q <= pwdata[`PMC_RQ_WRITE];
				addr_q <= rq_addr;
			end
			if (tmo_hit)
				tmo_pend_q <= 1'b1;
			else if (st_q == ST_END)
				tmo_pend_q <= 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// Pin drive
	// ---------------------------------------------------------------
	wire cs_act = (st_q == ST_LATCH) || (st_q == ST_HOLD) ||
		(st_q == ST_STROBE) || (st_q == ST_ACKW);
	wire stb_act = (st_q == ST_STROBE) || (st_q == ST_ACKW);
	wire sm = cfg[`PMC_CF_SM];
	wire write_strobe_polarity = cfg[`PMC_CF_WRITE_STROBE_POLARITY];
	wire read_strobe_polarity = cfg[`PMC_CF_READ_STROBE_POLARITY];
	wire byte_enable_polarity = cfg[`PMC_CF_BEP];
	wire wide = (cfg[`PMC_CF_W_HI:`PMC_CF_W_LO] == `PMC_WIDTH_16);

	always @(posedge clk) begin
		if (reset) begin
			address_bus_out <= 23'h000000;
			address_bus_oe <= 23'h000000;
			latch_strobe_low <= 1'b0;
			chip_select_one_out <= 1'b1;
			chip_select_one_oe <= 1'b0;
			chip_select_two_out <= 1'b1;
			chip_select_two_oe <= 1'b0;
			write_strobe_out <= 1'b1;
			write_strobe_oe <= 1'b0;
			read_strobe_out <= 1'b1;
			read_strobe_oe <= 1'b0;
			low_byte_enable_out <= 1'b1;
			low_byte_enable_oe <= 1'b0;
			high_byte_enable_out <= 1'b1;
			high_byte_enable_oe <= 1'b0;
		end else begin
			address_bus_out <= addr_q[22:0];
			address_bus_oe[22:16] <= strobe_q[6:0];
			address_bus_oe[15:14] <= low_pins_q[15:14];
			address_bus_oe[13:3] <= low_pins_q[13:3];
			address_bus_oe[2:0] <= low_pins_q[2:0];
			latch_strobe_low <= (st_q == ST_LATCH) & low_pins_q[0];
			chip_select_one_out <= (cs_act & !sel2_q) ? cfg_q[0][`PMC_CF_CSP] :
				~cfg_q[0][`PMC_CF_CSP];
			chip_select_two_out <= (cs_act & sel2_q) ? cfg_q[1][`PMC_CF_CSP] :
				~cfg_q[1][`PMC_CF_CSP];
			chip_select_one_oe <= cfg_q[0][`PMC_CF_CSPEN] & !cfg_q[0][`PMC_CF_OFF];
			chip_select_two_oe <= cfg_q[1][`PMC_CF_CSPEN] & !cfg_q[1][`PMC_CF_OFF];
			if (sm) begin
				write_strobe_out <= stb_act ? write_strobe_polarity : ~write_strobe_polarity;
				read_strobe_out <= (cs_act & !wr_q) ? read_strobe_polarity : ~read_strobe_polarity;
			end else begin
				write_strobe_out <= (stb_act & wr_q) ? write_strobe_polarity : ~write_strobe_polarity;
				read_strobe_out <= (stb_act & !wr_q) ? read_strobe_polarity : ~read_strobe_polarity;
			end
			low_byte_enable_out <= cs_act ? byte_enable_polarity : ~byte_enable_polarity;
			high_byte_enable_out <= (cs_act & wide) ? byte_enable_polarity : ~byte_enable_polarity;
			write_strobe_oe <= strobe_q[`PMC_SE_WR_EN];
			read_strobe_oe <= strobe_q[`PMC_SE_RD_EN];
			high_byte_enable_oe <= strobe_q[`PMC_SE_BE1_EN];
			low_byte_enable_oe <= strobe_q[`PMC_SE_BE0_EN];
		end
	end

	// ---------------------------------------------------------------
	// Register writes and flags
	// ---------------------------------------------------------------
	wire err_set = wr_req & !legal;
	wire tmo_set = (st_q == ST_END) & tmo_pend_q;

	always @(posedge clk) begin
		if (reset) begin
			port_mode_q <= 2'h0;
			err_q <= 1'b0;
			tmo_q <= 1'b0;
			reserved_space_top <= 8'h00;
			strobe_q <= `PMC_REG_RST;
			low_pins_q <= `PMC_REG_RST;
			cfg_q[0] <= `PMC_REG_RST;
			cfg_q[1] <= `PMC_REG_RST;
			base_q[0] <= `PMC_CS1_BASE_RST;
			base_q[1] <= `PMC_CS2_BASE_RST;
			mode_q[0] <= `PMC_REG_RST;
			mode_q[1] <= `PMC_REG_RST;
		end else begin
			// Set wins over a clear in the same cycle
			err_q <= err_set | (err_q & !(wr_status & !pwdata[`PMC_ST_ERROR]));
			tmo_q <= tmo_set | (tmo_q & !(wr_status & !pwdata[`PMC_ST_TIMEOUT]));
			if (wr_status)
				reserved_space_top <= pwdata[7:0];
			if (acc_wr) begin
				case (paddr)
					`PMC_OFF_MODE: port_mode_q <= pwdata[1:0];
					`PMC_OFF_STROBE: strobe_q <= pwdata[15:0] & `PMC_STROBE_MASK;
					`PMC_OFF_ADDR_EN: low_pins_q <= pwdata[15:0];
					`PMC_OFF_CS1_CFG: cfg_q[0] <= pwdata[15:0] & `PMC_CF_MASK;
					`PMC_OFF_CS2_CFG: cfg_q[1] <= pwdata[15:0] & `PMC_CF_MASK;
					`PMC_OFF_CS1_BASE: base_q[0] <= pwdata[15:0] & `PMC_BASE_MASK;
					`PMC_OFF_CS2_BASE: base_q[1] <= pwdata[15:0] & `PMC_BASE_MASK;
					`PMC_OFF_CS1_MODE: mode_q[0] <= pwdata[15:0] & `PMC_MD_MASK;
					`PMC_OFF_CS2_MODE: mode_q[1] <= pwdata[15:0] & `PMC_MD_MASK;
					default: begin
					end
				endcase
			end
		end
	end

	// ---------------------------------------------------------------
	// APB read and answer
	// ---------------------------------------------------------------
	reg [15:0] rd_d;
	reg map_d;

	always @* begin
		rd_d = 16'h0000;
		map_d = 1'b1;
		case (paddr)
			`PMC_OFF_MODE: rd_d = {14'h0000, port_mode_q};
			`PMC_OFF_STATUS: rd_d = {busy_q & master, 1'b0, err_q, tmo_q, 4'h0,
				reserved_space_top};
			`PMC_OFF_STROBE: rd_d = strobe_q;
			`PMC_OFF_ADDR_EN: rd_d = low_pins_q;
			`PMC_OFF_CS1_CFG: rd_d = cfg_q[0];
			`PMC_OFF_CS2_CFG: rd_d = cfg_q[1];
			`PMC_OFF_CS1_BASE: rd_d = base_q[0];
			`PMC_OFF_CS2_BASE: rd_d = base_q[1];
			`PMC_OFF_CS1_MODE: rd_d = mode_q[0];
			`PMC_OFF_CS2_MODE: rd_d = mode_q[1];
			`PMC_OFF_REQUEST: rd_d = 16'h0000;
			default: map_d = 1'b0;
		endcase
	end

	always @(posedge clk) begin
		if (reset) begin
			prdata <= 32'h00000000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= psel & !penable;
			if (psel & !penable) begin
				prdata <= {16'h0000, rd_d};
				pslverr <= !map_d;
			end else
				pslverr <= 1'b0;
		end
	end

endmodule

`default_nettype wire

// >>> dv/pmc_port_monitor.sv
// Checker of the pin enables and the bus answer of the parallel port block.
// Assumes it is bound into pmc_port and sees only that module's ports.
`timescale 1ns/100ps
`default_nettype none

module pmc_port_monitor (
	// Clock, reset and bus
	input wire clk,
	input wire reset,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	input wire pready,
	input wire pslverr,
	// Pin enables and latch strobe
	input wire [22:0] address_bus_oe,
	input wire latch_strobe_low,
	input wire chip_select_one_oe,
	input wire chip_select_two_oe,
	input wire write_strobe_oe,
	input wire read_strobe_oe,
	input wire high_byte_enable_oe,
	input wire low_byte_enable_oe
);
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	wire wr_done = psel && penable && pready && pwrite;

	// ----------------------------------------
	// Pin enables follow the register written; latch strobe only on an enabled pin
	// ----------------------------------------
	cs_one_en_a: assert property (
		wr_done && paddr == 8'h10 |-> ##2
		chip_select_one_oe == ($past(pwdata[13], 2) && !$past(pwdata[15], 2)))
		else $error("chip select one pin enable wrong");
	cs_two_en_a: assert property (
		wr_done && paddr == 8'h14 |-> ##2
		chip_select_two_oe == ($past(pwdata[13], 2) && !$past(pwdata[15], 2)))
		else $error("chip select two pin enable wrong");
	strobe_pin_en_a: assert property (
		wr_done && paddr == 8'h08 |-> ##2 {write_strobe_oe, read_strobe_oe,
		high_byte_enable_oe, low_byte_enable_oe} == $past(pwdata[15:12], 2))
		else $error("strobe pin enables wrong");
	upper_pin_en_a: assert property (
		wr_done && paddr == 8'h08 |-> ##2 address_bus_oe[22:16] == $past(pwdata[6:0], 2))
		else $error("upper address pin enables wrong");
	low_pin_en_a: assert property (
		wr_done && paddr == 8'h0c |-> ##2 address_bus_oe[15:0] == $past(pwdata[15:0], 2))
		else $error("low address pin enables wrong");
	latch_pin_a: assert property (
		latch_strobe_low |-> address_bus_oe[0])
		else $error("latch strobe on a disabled pin");

	// ----------------------------------------
	// Bus answer
	// ----------------------------------------
	bus_answer_a: assert property (psel && !penable |=> pready ##1 !pready)
		else $error("bus answer is not a single pulse after setup");
	bus_error_a: assert property (pslverr |-> pready)
		else $error("slave error without ready");

	cover property (wr_done && paddr == 8'h28);
	cover property (latch_strobe_low);
	cover property (pslverr);
endmodule

bind pmc_port pmc_port_monitor pmc_port_monitor_inst (.clk(clk), .reset(reset),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.pready(pready), .pslverr(pslverr), .address_bus_oe(address_bus_oe),
	.latch_strobe_low(latch_strobe_low), .chip_select_one_oe(chip_select_one_oe),
	.chip_select_two_oe(chip_select_two_oe), .write_strobe_oe(write_strobe_oe),
	.read_strobe_oe(read_strobe_oe), .high_byte_enable_oe(high_byte_enable_oe),
	.low_byte_enable_oe(low_byte_enable_oe));
`default_nettype wire

// >>> dv/pmc_ext_dev.sv
// Model of an external part that answers one chip select with acknowledge.
// Assumes the bench sets polarities, delay and whether it answers at all.
`timescale 1ns/100ps
`default_nettype none

module pmc_ext_dev (
	// Pins
	input wire logic clk,
	input wire logic cs_pin,
	output logic ack,
	// Behaviour
	input wire logic cs_high,
	input wire logic ack_high,
	input wire logic answer,
	input wire logic [7:0] delay
);
	logic [7:0] cnt = 8'h00;
	wire logic sel = (cs_pin === cs_high);

	initial ack = 1'b0;
	// Slow or prompt answer, held until deselected
	always @(posedge clk) begin
		cnt <= sel ? ((cnt == 8'hff) ? cnt : cnt + 8'h01) : 8'h00;
		ack <= (answer && sel && cnt >= delay) ? ack_high : !ack_high;
	end
endmodule
`default_nettype wire

// >>> dv/test_pmc_port.sv
// Self-checking bench of the parallel port block over its register bus.
// Assumes pmc_port, its checker and the external part model are compiled.
`timescale 1ns/100ps
`default_nettype none

module test_pmc_port;
	logic clk, reset, psel, penable, pwrite, pslverr, pready;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, r;
	logic e, ack1, ack2, ans, ack_polarity_sel;
	logic [22:0] abus, aoe;
	logic [5:0] seen;
	int lat_n, cs_n;
	logic cs1, cs2, wrs, rds, be0, be1, cs1_oe, cs2_oe, wr_oe, rd_oe, be0_oe, be1_oe, alat;
	int failures = 0;
	int tests_run = 0;

	pmc_port #(.QTR_CLKS(1)) pmc_port_inst (.clk(clk), .reset(reset), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .ack_input_one(ack1),
		.ack_input_two(ack2), .address_bus_out(abus), .address_bus_oe(aoe),
		.latch_strobe_low(alat), .chip_select_one_out(cs1), .chip_select_one_oe(cs1_oe),
		.chip_select_two_out(cs2), .chip_select_two_oe(cs2_oe), .write_strobe_out(wrs),
		.write_strobe_oe(wr_oe), .read_strobe_out(rds), .read_strobe_oe(rd_oe),
		.low_byte_enable_out(be0), .low_byte_enable_oe(be0_oe),
		.high_byte_enable_out(be1), .high_byte_enable_oe(be1_oe));
	pmc_ext_dev dev1_inst (.clk(clk), .cs_pin(cs1), .ack(ack1), .cs_high(1'b1),
		.ack_high(ack_polarity_sel), .answer(ans), .delay(8'h03));
	pmc_ext_dev dev2_inst (.clk(clk), .cs_pin(cs2), .ack(ack2), .cs_high(1'b1),
		.ack_high(ack_polarity_sel), .answer(ans), .delay(8'h00));

	// Active pins seen during a transfer, sampled where settled
	always @(negedge clk) begin
		seen = seen | {be1 === 1'b1, be0 === 1'b1, rds === 1'b1, wrs === 1'b1, cs2 === 1'b1,
			cs1 === 1'b1};
		lat_n = lat_n + (alat === 1'b1);
		cs_n = cs_n + (cs1 === 1'b1);
	end

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task summarize;
		$display("comparisons %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task fail(input string m);
		failures++;
		$display("ERROR %0t %s", $time, m);
	endtask

	task chk(input logic [63:0] g, input logic [63:0] x, input string m);
		tests_run++;
		if (g !== x) fail(m);
	endtask

	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) fail("no bus answer");
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask

	task wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task rchk(input logic [7:0] a, input logic [31:0] x, input string m);
		apb(1'b0, a, 32'h0);
		chk(r, x, m);
	endtask

	task run(input logic [31:0] d);
		int n;
		n = 0;
		seen = 6'h0;
		lat_n = 0;
		cs_n = 0;
		wr(8'h28, d);
		do begin
			apb(1'b0, 8'h04, 32'h0);
			n++;
		end while (r[15] !== 1'b0 && n < 600);
		if (n >= 600) fail("port stays busy");
	endtask

	// ----------------------------------------
	// Clock, watchdog and tests
	// ----------------------------------------
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	initial begin
		#(5 * 60000);
		fail("watchdog expired");
		summarize;
	end

	initial begin
		reset = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		ans = 1'b0;
		ack_polarity_sel = 1'b1;
		seen = 6'h0;
		repeat (10) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		for (int i = 0; i < 10; i++)
			rchk(8'(4 * i), (i == 6) ? 32'h0200 : (i == 7) ? 32'h0600 : 32'h0, "reset value");
		chk({cs1_oe, cs2_oe, wr_oe, rd_oe, be0_oe, be1_oe, aoe}, 32'h0, "pins enabled at reset");
		apb(1'b0, 8'h3c, 32'h0);
		chk({r, e}, 33'h1, "unmapped access");
		$display("test reset done");

		for (int i = 0; i < 5; i++) begin
			wr(8'h08 + 8'(4 * i), 32'hffff);
			rchk(8'h08 + 8'(4 * i), {16'hf77f, 16'hffff, 16'hf7e0, 16'hf7e0, 16'hff88} >>
				(16 * (4 - i)) & 32'hffff, "field mask");
		end
		chk({wr_oe, rd_oe, be1_oe, be0_oe, cs1_oe, aoe}, {4'hf, 1'b0, 23'h7fffff}, "pin enables");
		wr(8'h08, 32'hf07f);
		wr(8'h10, 32'h7680);
		wr(8'h14, 32'h7680);
		wr(8'h18, 32'h0200);
		chk({cs1_oe, cs2_oe}, 32'h3, "chip select pin enables");
		$display("test masks done");

		run(32'h01030000);
		chk(r, 32'h2000, "request outside master mode");
		wr(8'h04, 32'h2000);
		rchk(8'h04, 32'h2000, "error flag kept");
		wr(8'h04, 32'h0);
		wr(8'h00, 32'h3);
		wr(8'h10, 32'h76e0);
		run(32'h01030000);
		chk(r, 32'h2000, "reserved width accepted");
		wr(8'h04, 32'h0);
		wr(8'h10, 32'h7680);
		$display("test errors done");

		seen = 6'h0;
		wr(8'h28, 32'h01030000);
		rchk(8'h04, 32'h8000, "busy during transfer");
		run(32'h01030000);
		chk(r, 32'h2000, "request while busy");
		wr(8'h04, 32'h0);
		run(32'h01030000);
		chk({r, seen}, 38'h15, "separate write strobes");
		chk({abus, cs1}, {23'h030000, 1'b0}, "address and idle chip select");
		wr(8'h10, 32'h7780);
		run(32'h00030000);
		chk({r, seen}, 38'h1d, "combined strobes on read");
		wr(8'h10, 32'h7680);
		wr(8'h08, 32'hf77f);
		run(32'h01030000);
		chk(lat_n, 32'd14, "latch strobe width");
		chk(cs_n, 32'd21, "address hold after latch");
		wr(8'h08, 32'hf07f);
		$display("test transfers done");

		ans <= 1'b1;
		wr(8'h20, 32'h8000);
		run(32'h00030000);
		chk(r, 32'h0, "acknowledged transfer");
		ack_polarity_sel <= 1'b0;
		wr(8'h10, 32'h7600);
		run(32'h00030000);
		chk(r, 32'h0, "active-low acknowledge");
		ack_polarity_sel <= 1'b1;
		wr(8'h10, 32'h7680);
		ans <= 1'b0;
		wr(8'h20, 32'h4004);
		run(32'h00030000);
		chk({r, cs1}, 33'h2000, "short time-out");
		wr(8'h04, 32'h0);
		wr(8'h20, 32'h4000);
		run(32'h01030000);
		chk(r, 32'h1000, "long time-out");
		wr(8'h04, 32'h1000);
		rchk(8'h04, 32'h1000, "time-out flag kept");
		wr(8'h04, 32'h0);
		wr(8'h20, 32'h0);
		$display("test acknowledge done");

		wr(8'h14, 32'h76c0);
		run(32'h01060000);
		chk({r, seen}, 38'h36, "second chip select, wide port");
		wr(8'h04, 32'h0007);
		run(32'h01080000);
		chk(r, 32'h2007, "address above reserved top");
		wr(8'h04, 32'h0);
		wr(8'h1c, 32'h0);
		run(32'h01700000);
		chk({r, seen}, 38'h15, "first chip select to top");
		$display("test decode done");
		summarize;
	end
endmodule
`default_nettype wire
